// [core/fpu_status_pkg.sv]
// package: status-word layout, command codes and state carrier for the flag logic
//
// Contract
// - six sticky exception flags kept in status bits zero to five
// - summary bit seven set when any unmasked exception flag is set
// - masked exception still sets its flag but not the summary bit
// - summary bit set drives the exception handler request output
// - flags stay set across error-free operations until explicit clear
// - clear, initialize and save commands clear all exception flags
// - restore and environment load overwrite flags from loaded image
// - status bit fifteen always mirrors the summary bit
// - compare writes outcome to bits zero, three; unordered to two; one is fault/zero
// - integer-flag compare leaves cond bits undefined, bit one for fault direction
// - arithmetic class sets bit one to roundup or fault direction
// - trig class sets bit two on out-of-range source, else clears it
// - load class sets bit one to zero or fault direction
// - environment load and restore load each condition bit from image
// - housekeeping instructions may leave condition bits undefined
// - stack-fault flag bit six set on register stack overflow or underflow
// - invalid operand without stack fault never clears stack-fault flag
// - on stack fault, bit one is one for overflow, zero for underflow
// - stack-fault flag held until initialize, clear or save command; restore and environment load also reload it from image bit six
// - six mask bits from control word bits zero to five block exceptions
// - examine writes sign to bit one, class to the other bits
// - remainder writes quotient bits to zero, three, one; incomplete to two
package fpu_status_pkg;

    localparam int EXC_COUNT = 6;
    // status word field positions
    localparam int SW_EXC_LO = 0;
    localparam int SW_SF_BIT = 6;
    localparam int SW_ES_BIT = 7;
    localparam int SW_C0_BIT = 8;
    localparam int SW_C1_BIT = 9;
    localparam int SW_C2_BIT = 10;
    localparam int SW_C3_BIT = 14;
    localparam int SW_BUSY_BIT = 15;
    // control word mask field
    localparam int CW_MASK_LO = 0;
    // reset values
    localparam logic [5:0] EXC_RESET = 6'h00;
    localparam logic [5:0] MASK_RESET = 6'h3F;
    localparam logic [3:0] COND_RESET = 4'h0;

    // instruction class reported by the execution core
    typedef enum logic [3:0] {
        CLS_NONE = 4'b0000,
        CLS_COMPARE = 4'b0001,
        CLS_COMPARE_INT = 4'b0010,
        CLS_EXAMINE = 4'b0011,
        CLS_REMAINDER = 4'b0100,
        CLS_ARITH = 4'b0101,
        CLS_TRIG = 4'b0110,
        CLS_LOAD = 4'b0111,
        CLS_CLEAR_EXC = 4'b1000,
        CLS_INIT = 4'b1001,
        CLS_SAVE = 4'b1010,
        CLS_RESTORE = 4'b1011,
        CLS_ENV_LOAD = 4'b1100,
        CLS_HOUSEKEEP = 4'b1101
    } instr_class_t;

    // one completed instruction from the core
    typedef struct packed {
        logic valid;
        instr_class_t cls;
        logic [5:0] exc;
        logic stack_fault;
        logic stack_overflow;
        logic [3:0] result_cond;
        logic round_up;
        logic [15:0] image_sw;
    } retire_t;

    typedef struct packed {
        logic [5:0] exc_flags;
        logic stack_fault_flag;
        logic [3:0] cond;
        logic [5:0] mask;
    } flag_state_t;

endpackage : fpu_status_pkg

// [core/fpu_status_flag_logic.sv]
// status-word exception, stack-fault and condition-code flag logic
`timescale 1ns/100ps
module fpu_status_flag_logic
    import fpu_status_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // instruction results from the execution core
    input wire retire_t retire_i,
    // control word exception masks, loaded by the core
    input wire logic mask_load_i,
    input wire logic [5:0] mask_value_i,
    // status word and handler request
    output logic [15:0] status_word_o,
    output logic exception_request_o
);

    flag_state_t state;
    flag_state_t next_state;

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        logic [3:0] c;
        c = state.cond;
        next_state = state;
        if (mask_load_i) begin
            next_state.mask = mask_value_i;
        end
        if (retire_i.valid) begin
            // sticky set, never cleared by plain results
            next_state.exc_flags = state.exc_flags | retire_i.exc;
            if (retire_i.stack_fault) begin
                next_state.stack_fault_flag = 1'b1;
            end
            case (retire_i.cls)
                CLS_COMPARE: begin
                    c = retire_i.result_cond;
                    c[1] = 1'b0;
                end
                CLS_COMPARE_INT: begin
                    c[1] = 1'b0;
                end
                CLS_EXAMINE: begin
                    c = retire_i.result_cond;
                end
                CLS_REMAINDER: begin
                    // quotient bits, core packs them in place
                    c = retire_i.result_cond;
                end
                CLS_ARITH: begin
                    c[1] = retire_i.round_up;
                end
                CLS_TRIG: begin
                    c[2] = retire_i.result_cond[2];
                    c[1] = retire_i.result_cond[2] ? 1'b0 : retire_i.round_up;
                end
                CLS_LOAD: begin
                    c[1] = 1'b0;
                end
                CLS_CLEAR_EXC: begin
                    next_state.exc_flags = EXC_RESET;
                    next_state.stack_fault_flag = 1'b0;
                end
                CLS_INIT, CLS_SAVE: begin
                    next_state.exc_flags = EXC_RESET;
                    next_state.stack_fault_flag = 1'b0;
                    next_state.mask = MASK_RESET;
                    c = COND_RESET;
                end
                CLS_RESTORE, CLS_ENV_LOAD: begin
                    // image overwrites flags and condition bits
                    next_state.exc_flags = retire_i.image_sw[SW_EXC_LO +: EXC_COUNT];
                    next_state.stack_fault_flag = retire_i.image_sw[SW_SF_BIT];
                    c = {retire_i.image_sw[SW_C3_BIT], retire_i.image_sw[SW_C2_BIT],
                         retire_i.image_sw[SW_C1_BIT], retire_i.image_sw[SW_C0_BIT]};
                end
                default: begin
                    // housekeeping leaves condition bits as they were
                    c = state.cond;
                end
            endcase
            if (retire_i.stack_fault) begin
                c[1] = retire_i.stack_overflow;
            end
        end
        next_state.cond = c;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= '{exc_flags: EXC_RESET, stack_fault_flag: 1'b0,
                       cond: COND_RESET, mask: MASK_RESET};
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // status word
    // ****************************************************************
    logic summary;
    // unmasked flags only, recomputed every cycle
    assign summary = |(state.exc_flags & ~state.mask);
    assign exception_request_o = summary;

    always_comb begin
        status_word_o = 16'h0000;
        status_word_o[SW_EXC_LO +: EXC_COUNT] = state.exc_flags;
        status_word_o[SW_SF_BIT] = state.stack_fault_flag;
        status_word_o[SW_ES_BIT] = summary;
        status_word_o[SW_C0_BIT] = state.cond[0];
        status_word_o[SW_C1_BIT] = state.cond[1];
        status_word_o[SW_C2_BIT] = state.cond[2];
        status_word_o[SW_C3_BIT] = state.cond[3];
        status_word_o[SW_BUSY_BIT] = summary;
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // helper terms for the checks; a plain retire never overwrites flags
    logic plain_retire;
    logic fault_free;
    assign plain_retire = retire_i.valid && !(retire_i.cls inside {CLS_CLEAR_EXC, CLS_INIT,
        CLS_SAVE, CLS_RESTORE, CLS_ENV_LOAD});
    assign fault_free = !retire_i.stack_fault;

    // ****************************************************************
    // summary and flag checks
    // ****************************************************************
    // reset leaves clean word
    reset_state_a: assert property (@(posedge clk_i)
        rst_i |=> status_word_o == 16'h0000 && !exception_request_o)
        else $error("status word not clean after reset");

    summary_mirror_a: assert property (@(posedge clk_i) disable iff (rst_i)
        status_word_o[SW_BUSY_BIT] == status_word_o[SW_ES_BIT])
        else $error("busy bit differs from summary");

    summary_unmasked_a: assert property (@(posedge clk_i) disable iff (rst_i)
        status_word_o[SW_ES_BIT] == |(status_word_o[5:0] & ~state.mask))
        else $error("summary does not match unmasked flags");

    masked_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (plain_retire && !mask_load_i
         && ((status_word_o[5:0] | retire_i.exc) & ~state.mask) == 6'h00)
        |=> !status_word_o[SW_ES_BIT])
        else $error("masked exception raised summary");

    request_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
        exception_request_o == status_word_o[SW_ES_BIT])
        else $error("handler request does not follow summary");

    flags_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        plain_retire |=> ((status_word_o[5:0] & $past(status_word_o[5:0]))
         == $past(status_word_o[5:0])))
        else $error("exception flag lost");

    flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls == CLS_ARITH) |=>
        ((status_word_o[5:0] & $past(retire_i.exc)) == $past(retire_i.exc)))
        else $error("detected exception not flagged");

    clear_cmd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls inside {CLS_CLEAR_EXC, CLS_INIT, CLS_SAVE})
        |=> status_word_o[6:0] == 7'h00)
        else $error("flags not cleared by command");

    init_defaults_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls inside {CLS_INIT, CLS_SAVE} && fault_free)
        |=> state.cond == COND_RESET && state.mask == MASK_RESET)
        else $error("initialize left condition or masks");

    restore_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls inside {CLS_RESTORE, CLS_ENV_LOAD})
        |=> status_word_o[5:0] == $past(retire_i.image_sw[5:0]))
        else $error("flags not taken from image");

    mask_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mask_load_i && !(retire_i.valid && retire_i.cls inside {CLS_INIT, CLS_SAVE}))
        |=> state.mask == $past(mask_value_i))
        else $error("mask not loaded");

    summary_recalc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mask_load_i && !retire_i.valid) |=>
        status_word_o[SW_ES_BIT] == |(status_word_o[5:0] & ~$past(mask_value_i)))
        else $error("summary stale after mask change");

    // ****************************************************************
    // stack fault checks
    // ****************************************************************
    // fault sets flag
    fault_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (plain_retire && retire_i.stack_fault) |=> status_word_o[SW_SF_BIT] &&
        status_word_o[SW_C1_BIT] == $past(retire_i.stack_overflow))
        else $error("stack fault or direction wrong");

    fault_kept_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (plain_retire && fault_free && status_word_o[SW_SF_BIT])
        |=> status_word_o[SW_SF_BIT])
        else $error("stack fault flag dropped");

    fault_direction_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.stack_fault)
        |=> status_word_o[SW_C1_BIT] == $past(retire_i.stack_overflow))
        else $error("fault direction wrong");

    fault_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls inside {CLS_CLEAR_EXC, CLS_INIT, CLS_SAVE})
        |=> !status_word_o[SW_SF_BIT])
        else $error("stack fault flag not cleared");

    // ****************************************************************
    // condition code checks
    // ****************************************************************
    // image condition bits
    restore_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls inside {CLS_RESTORE, CLS_ENV_LOAD} && fault_free)
        |=> status_word_o[SW_C3_BIT] == $past(retire_i.image_sw[SW_C3_BIT])
        && status_word_o[10:8] == $past(retire_i.image_sw[10:8])
        && status_word_o[6:0] == $past(retire_i.image_sw[6:0]))
        else $error("image not loaded");

    compare_outcome_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls == CLS_COMPARE && fault_free)
        |=> state.cond == ($past(retire_i.result_cond) & 4'b1101))
        else $error("compare outcome wrong");

    compare_int_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls == CLS_COMPARE_INT && fault_free)
        |=> !status_word_o[SW_C1_BIT])
        else $error("integer compare bit one wrong");

    arith_round_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls == CLS_ARITH && fault_free)
        |=> status_word_o[SW_C1_BIT] == $past(retire_i.round_up))
        else $error("rounding direction wrong");

    trig_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls == CLS_TRIG) |=>
        status_word_o[SW_C2_BIT] == $past(retire_i.result_cond[2]))
        else $error("range bit wrong");

    trig_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls == CLS_TRIG && retire_i.result_cond[2] && fault_free)
        |=> !status_word_o[SW_C1_BIT])
        else $error("bit one set while out of range");

    load_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls == CLS_LOAD && fault_free)
        |=> !status_word_o[SW_C1_BIT])
        else $error("load left bit one set");

    housekeep_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls inside {CLS_NONE, CLS_HOUSEKEEP} && fault_free)
        |=> state.cond == $past(state.cond))
        else $error("housekeeping moved condition bits");

    examine_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls == CLS_EXAMINE && fault_free)
        |=> state.cond == $past(retire_i.result_cond))
        else $error("examine result wrong");

    remainder_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (retire_i.valid && retire_i.cls == CLS_REMAINDER && fault_free)
        |=> state.cond == $past(retire_i.result_cond))
        else $error("remainder result wrong");

endmodule : fpu_status_flag_logic

// [testbench/core_model.sv]
// execution core stand-in: retires one instruction per cycle into the flag logic
`timescale 1ns/100ps
module core_model
    import fpu_status_pkg::*;
(
    // clock
    input wire logic clk_i,
    // toward the flag logic
    output retire_t retire_o,
    output logic mask_load_o,
    output logic [5:0] mask_value_o
);
    initial begin
        retire_o = '0;
        mask_load_o = 1'b0;
        mask_value_o = 6'h00;
    end

    // status is never read back, so no condition bit is relied on
    task automatic issue(input retire_t r, input logic ml, input logic [5:0] mv);
        @(negedge clk_i);
        // idle cycles carry junk in every field but valid
        retire_o <= r.valid ? r : {1'b0, ~retire_o[$bits(retire_t)-2:0]};
        mask_load_o <= ml;
        mask_value_o <= ml ? mv : ~mask_value_o;
    endtask : issue
endmodule : core_model

// [testbench/tb_top.sv]
// self-checking bench for the status flag logic
`timescale 1ns/100ps
module tb_top
    import fpu_status_pkg::*;
;
    logic clk_i;
    logic rst_i;
    retire_t retire_i;
    logic mask_load_i;
    logic [5:0] mask_value_i;
    logic [15:0] status_word_o;
    logic exception_request_o;
    logic [5:0] m_exc = 6'h00;
    logic [5:0] m_mask = 6'h3F;
    logic m_sf = 1'b0;
    logic [3:0] m_cond = 4'h0;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 2501;

    core_model core_u (.clk_i(clk_i), .retire_o(retire_i), .mask_load_o(mask_load_i),
        .mask_value_o(mask_value_i));
    fpu_status_flag_logic dut_u (.clk_i(clk_i), .rst_i(rst_i), .retire_i(retire_i),
        .mask_load_i(mask_load_i), .mask_value_i(mask_value_i),
        .status_word_o(status_word_o), .exception_request_o(exception_request_o));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    function automatic logic [15:0] exp_sw();
        logic es;
        es = |(m_exc & ~m_mask);
        return {es, m_cond[3], 3'b000, m_cond[2:0], es, m_sf, m_exc};
    endfunction : exp_sw

    task automatic model(input retire_t r, input logic ml, input logic [5:0] mv);
        logic d;
        logic [3:0] rc;
        rc = r.result_cond;
        d = r.stack_fault ? r.stack_overflow : 1'b0;
        if (ml) m_mask = mv;
        if (!r.valid) return;
        if (r.cls inside {CLS_CLEAR_EXC, CLS_INIT, CLS_SAVE}) begin
            m_exc = 6'h00;
            m_sf = 1'b0;
        end else if (r.cls inside {CLS_RESTORE, CLS_ENV_LOAD}) begin
            m_exc = r.image_sw[5:0];
            m_sf = r.image_sw[6];
            m_cond = {r.image_sw[14], r.image_sw[10:8]};
        end else begin
            m_exc = m_exc | r.exc;
            m_sf = m_sf | r.stack_fault;
        end
        case (r.cls)
            CLS_COMPARE: m_cond = {rc[3:2], d, rc[0]};
            CLS_COMPARE_INT: m_cond[1] = d;
            CLS_EXAMINE: m_cond = rc;
            CLS_REMAINDER: m_cond = {rc[3:2], r.stack_fault ? d : rc[1], rc[0]};
            CLS_ARITH: m_cond[1] = r.stack_fault ? d : r.round_up;
            CLS_TRIG: m_cond[2:1] = {rc[2], rc[2] ? 1'b0 : r.round_up};
            CLS_LOAD: m_cond[1] = d;
            CLS_INIT, CLS_SAVE: begin
                m_cond = 4'h0;
                m_mask = 6'h3F;
            end
            default: m_cond = m_cond;
        endcase
    endtask : model

    task automatic go(input instr_class_t c, input logic [5:0] e, input logic f,
        input logic ml, input logic [5:0] mv);
        retire_t r;
        logic [16:0] exp;
        logic [15:0] sw;
        r = retire_t'({$random(seed), $random(seed)});
        r.valid = c != CLS_NONE;
        r.cls = c;
        r.exc = e;
        r.stack_fault = f;
        core_u.issue(r, ml, mv);
        model(r, ml, mv);
        @(posedge clk_i);
        #1;
        sw = exp_sw();
        exp = {sw[15], sw};
        total_checks++;
        // every flag, summary, mirror and request bit
        if ({exception_request_o, status_word_o} !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time,
                {exception_request_o, status_word_o}, exp);
        end
    endtask : go

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // ceiling well above the ~620 cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            wrap_up();
        end
    end

    initial begin
        instr_class_t c;
        logic big;
        logic fok;
        rst_i = 1'b1;
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        go(CLS_NONE, 6'h00, 1'b0, 1'b0, 6'h00);
        go(CLS_ARITH, 6'h01, 1'b0, 1'b0, 6'h00);
        go(CLS_NONE, 6'h00, 1'b0, 1'b1, 6'h00);
        go(CLS_HOUSEKEEP, 6'h00, 1'b0, 1'b0, 6'h00);
        go(CLS_LOAD, 6'h01, 1'b1, 1'b0, 6'h00);
        go(CLS_ARITH, 6'h01, 1'b0, 1'b0, 6'h00);
        go(CLS_CLEAR_EXC, 6'h00, 1'b0, 1'b0, 6'h00);
        go(CLS_RESTORE, 6'h00, 1'b0, 1'b0, 6'h00);
        go(CLS_ENV_LOAD, 6'h00, 1'b0, 1'b1, 6'h2A);
        go(CLS_SAVE, 6'h00, 1'b0, 1'b0, 6'h00);
        $display("test directed done");
        for (int i = 0; i < 600; i++) begin
            c = instr_class_t'(4'($unsigned($random(seed)) % 14));
            big = c inside {CLS_CLEAR_EXC, CLS_INIT, CLS_SAVE, CLS_RESTORE, CLS_ENV_LOAD};
            fok = c inside {CLS_COMPARE, CLS_COMPARE_INT, CLS_ARITH, CLS_LOAD, CLS_REMAINDER};
            go(c, big ? 6'h00 : 6'($random(seed)) & 6'($random(seed)),
                fok && ($random(seed) % 4 == 0), !big && ($random(seed) % 4 == 0),
                6'($random(seed)));
        end
        $display("test random done");
        wrap_up();
    end
endmodule : tb_top
